// file: hdl/aim_flag_if.sv
// Purpose: Carries status flags and enables to the interrupt gate
// Assumes: Flags and mask share one bit layout
// Notes:   Irq comes back as a plain level
interface aim_flag_if #(
  parameter int W = 8
);
  logic [W-1:0] flags;
  logic [W-1:0] mask;
  logic         irq;

  modport src  (output flags, output mask, input  irq);
  modport gate (input  flags, input  mask, output irq);
endinterface : aim_flag_if

// file: hdl/aim_irq_gate.sv
// Purpose: Gates each status flag by its enable and merges them
// Assumes: Flags and mask are register outputs
// Notes:   Purely combinational; request is a level
module aim_irq_gate #(
  parameter int W = 8
) (
  aim_flag_if.gate fi
);

  logic [W-1:0] gated;

  // ----------------------------------------------------------------
  // Per-source gate
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_src
    assign gated[i] = fi.flags[i] & fi.mask[i];
  end

  // Any enabled source raises the request
  assign fi.irq = |gated;

endmodule : aim_irq_gate

// file: hdl/aim_pkg.sv
// Purpose: Shared constants for the ADC interrupt mask and mode block
// Assumes: 40 MHz system clock, 32-bit register port with byte addresses
// Notes:   Status and data offsets sit beside the mask and mode words
package aim_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W              = 32;
  localparam int unsigned   DATA_W              = 32;
  localparam logic [31:0]   OFF_STATUS          = 32'hffff0500;
  localparam logic [31:0]   OFF_IRQ_MASK        = 32'hffff0504;
  localparam logic [31:0]   OFF_MODE            = 32'hffff0508;
  localparam logic [31:0]   OFF_PRIMARY_DATA    = 32'hffff0510;
  localparam logic [31:0]   OFF_AUX_DATA        = 32'hffff0514;

  // ----------------------------------------------------------------
  // Status and mask layout (same bit positions in both)
  // ----------------------------------------------------------------
  localparam int unsigned   FLAG_W              = 8;
  localparam int unsigned   BIT_PRIMARY_READY   = 0;
  localparam int unsigned   BIT_AUX_READY       = 1;
  localparam int unsigned   BIT_OVERRANGE       = 3;
  localparam int unsigned   BIT_THRESHOLD       = 4;
  localparam int unsigned   BIT_ACCUM_THRESHOLD = 6;
  localparam logic [7:0]    FLAG_IMPL           = 8'h5b;
  localparam logic [7:0]    MASK_RESET          = 8'h00;
  localparam logic [7:0]    STATUS_RESET        = 8'h00;

  // ----------------------------------------------------------------
  // Mode register layout
  // ----------------------------------------------------------------
  localparam int unsigned   MODE_W              = 8;
  localparam logic [7:0]    MODE_RESET          = 8'h03;
  localparam int unsigned   BIT_CLOCK_SELECT    = 7;
  localparam int unsigned   BIT_LOW_POWER_EN    = 5;
  localparam int unsigned   PM_FIELD_HI         = 4;
  localparam int unsigned   PM_FIELD_LO         = 3;
  // Odd power mode codes (01, 11) mean low power
  localparam int unsigned   PM_LOW_POWER_BIT    = 3;

  // ----------------------------------------------------------------
  // Modulator clock rates
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ            = 40_000_000;
  localparam longint unsigned MOD_FAST_HZ       = 512_000;
  localparam longint unsigned MOD_SLOW_HZ       = 131_000;
  localparam int unsigned     PHASE_W           = 24;
  localparam logic [23:0]     PHASE_INC_FAST    =
    24'((MOD_FAST_HZ << PHASE_W) / CLK_HZ);
  localparam logic [23:0]     PHASE_INC_SLOW    =
    24'((MOD_SLOW_HZ << PHASE_W) / CLK_HZ);

  localparam int unsigned   RESULT_W            = 24;

endpackage : aim_pkg

// file: hdl/aim_top.sv
// Purpose: ADC interrupt enable mask, status flags and mode register
// Assumes: One clock, synchronous active-low reset, one-cycle strobes
// Notes:   Read data stand only in the cycle after the read strobe
//
// What this block does
// - Mask bit enables same-position status flag
// - Mask reads all zeros after reset
// - Bit 6 gates accumulator threshold flag
// - Bit 4 gates primary threshold flag
// - Bit 3 gates primary overrange flag
// - Bit 1 gates auxiliary ready flag
// - Bit 0 gates primary ready flag
// - Mode register eight bits, resets 0x03
// - Mode bit 7 picks 512 or 131 kHz
// - Low-power enable ignored in normal mode
// - Power codes 00/10 normal, 01/11 low
// - Primary ready set on result, read clears
//
// Decided for this implementation: the strobed register port.
module aim_top #(
  parameter int RESULT_W = aim_pkg::RESULT_W
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [31:0]           bus_addr,
  input  wire logic [31:0]           bus_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  output      logic [31:0]           bus_rdata,
  input  wire logic                  primary_result_valid,
  input  wire logic [RESULT_W-1:0]   primary_result_in,
  input  wire logic                  aux_result_valid,
  input  wire logic [RESULT_W-1:0]   aux_result_in,
  input  wire logic                  accum_threshold_in,
  input  wire logic                  primary_threshold_in,
  input  wire logic                  primary_overrange_in,
  output      logic                  adc_irq,
  output      logic                  modulator_clock_select,
  output      logic                  modulator_clock_tick,
  output      logic [1:0]            power_mode_field,
  output      logic                  low_power_enable,
  output      logic                  low_power_active
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]          adc_interrupt_enable_mask_q;
  logic [7:0]          adc_interrupt_enable_mask_d;
  logic [7:0]          adc_operating_mode_q;
  logic [7:0]          adc_operating_mode_d;
  logic [7:0]          adc_status_flags_q;
  logic [7:0]          adc_status_flags_d;
  logic [RESULT_W-1:0] primary_result_data_q;
  logic [RESULT_W-1:0] primary_result_data_d;
  logic [RESULT_W-1:0] aux_result_data_q;
  logic [RESULT_W-1:0] aux_result_data_d;
  logic                aux_read_seen_q;
  logic                aux_read_seen_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic [aim_pkg::PHASE_W-1:0] phase_q;
  logic [aim_pkg::PHASE_W-1:0] phase_d;
  logic                tick_q;
  logic                tick_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_status;
  logic sel_mask;
  logic sel_mode;
  logic sel_primary;
  logic sel_aux;
  logic wr_mask;
  logic wr_mode;
  logic wr_status;
  logic rd_primary;
  logic rd_aux;

  assign sel_status  = bus_addr == aim_pkg::OFF_STATUS;
  assign sel_mask    = bus_addr == aim_pkg::OFF_IRQ_MASK;
  assign sel_mode    = bus_addr == aim_pkg::OFF_MODE;
  assign sel_primary = bus_addr == aim_pkg::OFF_PRIMARY_DATA;
  assign sel_aux     = bus_addr == aim_pkg::OFF_AUX_DATA;
  assign wr_mask     = bus_wr & sel_mask;
  assign wr_mode     = bus_wr & sel_mode;
  assign wr_status   = bus_wr & sel_status;
  assign rd_primary  = bus_rd & sel_primary;
  assign rd_aux      = bus_rd & sel_aux;

  // ----------------------------------------------------------------
  // Interrupt enable mask
  // ----------------------------------------------------------------
  // Reserved positions are not stored and read as zero
  assign adc_interrupt_enable_mask_d = wr_mask
    ? (bus_wdata[7:0] & aim_pkg::FLAG_IMPL)
    : adc_interrupt_enable_mask_q;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  assign adc_operating_mode_d = wr_mode ? bus_wdata[7:0]
                                        : adc_operating_mode_q;

  assign modulator_clock_select =
    adc_operating_mode_q[aim_pkg::BIT_CLOCK_SELECT];
  assign power_mode_field =
    adc_operating_mode_q[aim_pkg::PM_FIELD_HI:aim_pkg::PM_FIELD_LO];
  // Odd codes are low power, even codes normal
  assign low_power_active =
    adc_operating_mode_q[aim_pkg::PM_LOW_POWER_BIT];
  // Enable only reaches the converter in a low-power code
  assign low_power_enable = low_power_active
    & adc_operating_mode_q[aim_pkg::BIT_LOW_POWER_EN];

  // ----------------------------------------------------------------
  // Modulator clock tick
  // ----------------------------------------------------------------
  // 40 MHz is no whole multiple of either rate, so a phase
  // accumulator spreads the ticks; jitter is one system cycle.
  logic [aim_pkg::PHASE_W-1:0] phase_inc;
  logic [aim_pkg::PHASE_W:0]   phase_sum;

  assign phase_inc = modulator_clock_select
    ? aim_pkg::PHASE_INC_FAST
    : aim_pkg::PHASE_INC_SLOW;
  assign phase_sum = {1'b0, phase_q} + {1'b0, phase_inc};
  assign phase_d   = phase_sum[aim_pkg::PHASE_W-1:0];
  assign tick_d    = phase_sum[aim_pkg::PHASE_W];
  assign modulator_clock_tick = tick_q;

  // ----------------------------------------------------------------
  // Result data capture
  // ----------------------------------------------------------------
  assign primary_result_data_d = primary_result_valid
    ? primary_result_in : primary_result_data_q;
  assign aux_result_data_d = aux_result_valid
    ? aux_result_in : aux_result_data_q;

  // Aux ready clears on aux read followed by primary read, or on a status write of its bit
  assign aux_read_seen_d = rd_aux ? 1'b1
                         : (rd_primary ? 1'b0 : aux_read_seen_q);

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A set in the same cycle as its clear wins, so no event is lost
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = '0;
    flag_set[aim_pkg::BIT_PRIMARY_READY]   = primary_result_valid;
    flag_set[aim_pkg::BIT_AUX_READY]       = aux_result_valid;
    flag_set[aim_pkg::BIT_OVERRANGE]       = primary_overrange_in;
    flag_set[aim_pkg::BIT_THRESHOLD]       = primary_threshold_in;
    flag_set[aim_pkg::BIT_ACCUM_THRESHOLD] = accum_threshold_in;
  end

  always_comb begin
    flag_clr = wr_status ? bus_wdata[7:0] : 8'h00;
    if (rd_primary) begin
      flag_clr[aim_pkg::BIT_PRIMARY_READY] = 1'b1;
    end
    if (rd_primary && aux_read_seen_q) begin
      flag_clr[aim_pkg::BIT_AUX_READY] = 1'b1;
    end
  end

  assign adc_status_flags_d =
    (flag_set | (adc_status_flags_q & ~flag_clr)) & aim_pkg::FLAG_IMPL;

  // ----------------------------------------------------------------
  // Named enable and flag fields
  // ----------------------------------------------------------------
  // Only named sources reach the gate; reserved positions stay zero
  logic       accum_threshold_irq_enable;
  logic       primary_threshold_irq_enable;
  logic       primary_overrange_irq_enable;
  logic       aux_ready_irq_enable;
  logic       primary_ready_irq_enable;
  logic       accum_threshold_flag;
  logic       primary_threshold_flag;
  logic       primary_overrange_flag;
  logic       aux_ready_flag;
  logic       primary_ready_flag;
  logic [7:0] gate_flags;
  logic [7:0] gate_mask;

  assign accum_threshold_irq_enable =
    adc_interrupt_enable_mask_q[aim_pkg::BIT_ACCUM_THRESHOLD];
  assign primary_threshold_irq_enable =
    adc_interrupt_enable_mask_q[aim_pkg::BIT_THRESHOLD];
  assign primary_overrange_irq_enable =
    adc_interrupt_enable_mask_q[aim_pkg::BIT_OVERRANGE];
  assign aux_ready_irq_enable =
    adc_interrupt_enable_mask_q[aim_pkg::BIT_AUX_READY];
  assign primary_ready_irq_enable =
    adc_interrupt_enable_mask_q[aim_pkg::BIT_PRIMARY_READY];

  assign accum_threshold_flag =
    adc_status_flags_q[aim_pkg::BIT_ACCUM_THRESHOLD];
  assign primary_threshold_flag =
    adc_status_flags_q[aim_pkg::BIT_THRESHOLD];
  assign primary_overrange_flag =
    adc_status_flags_q[aim_pkg::BIT_OVERRANGE];
  assign aux_ready_flag =
    adc_status_flags_q[aim_pkg::BIT_AUX_READY];
  assign primary_ready_flag =
    adc_status_flags_q[aim_pkg::BIT_PRIMARY_READY];

  always_comb begin
    gate_mask = '0;
    gate_mask[aim_pkg::BIT_ACCUM_THRESHOLD] = accum_threshold_irq_enable;
    gate_mask[aim_pkg::BIT_THRESHOLD]       = primary_threshold_irq_enable;
    gate_mask[aim_pkg::BIT_OVERRANGE]       = primary_overrange_irq_enable;
    gate_mask[aim_pkg::BIT_AUX_READY]       = aux_ready_irq_enable;
    gate_mask[aim_pkg::BIT_PRIMARY_READY]   = primary_ready_irq_enable;
  end

  always_comb begin
    gate_flags = '0;
    gate_flags[aim_pkg::BIT_ACCUM_THRESHOLD] = accum_threshold_flag;
    gate_flags[aim_pkg::BIT_THRESHOLD]       = primary_threshold_flag;
    gate_flags[aim_pkg::BIT_OVERRANGE]       = primary_overrange_flag;
    gate_flags[aim_pkg::BIT_AUX_READY]       = aux_ready_flag;
    gate_flags[aim_pkg::BIT_PRIMARY_READY]   = primary_ready_flag;
  end

  // ----------------------------------------------------------------
  // Interrupt gate
  // ----------------------------------------------------------------
  aim_flag_if #(.W(aim_pkg::FLAG_W)) flag_bus ();

  assign flag_bus.flags = gate_flags;
  assign flag_bus.mask  = gate_mask;

  aim_irq_gate #(.W(aim_pkg::FLAG_W)) u_irq_gate (
    .fi (flag_bus.gate)
  );

  assign adc_irq = flag_bus.irq;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  logic [31:0] read_value;

  assign read_value =
      sel_status  ? {24'h000000, adc_status_flags_q}
    : sel_mask    ? {24'h000000, adc_interrupt_enable_mask_q}
    : sel_mode    ? {24'h000000, adc_operating_mode_q}
    : sel_primary ? 32'(primary_result_data_q)
    : sel_aux     ? 32'(aux_result_data_q)
    : 32'h00000000;

  assign rdata_d   = bus_rd ? read_value : 32'h00000000;
  assign bus_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      adc_interrupt_enable_mask_q <= aim_pkg::MASK_RESET;
      adc_operating_mode_q        <= aim_pkg::MODE_RESET;
      adc_status_flags_q          <= aim_pkg::STATUS_RESET;
    end else begin
      adc_interrupt_enable_mask_q <= adc_interrupt_enable_mask_d;
      adc_operating_mode_q        <= adc_operating_mode_d;
      adc_status_flags_q          <= adc_status_flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      primary_result_data_q <= '0;
      aux_result_data_q     <= '0;
      aux_read_seen_q       <= 1'b0;
      rdata_q               <= 32'h00000000;
    end else begin
      primary_result_data_q <= primary_result_data_d;
      aux_result_data_q     <= aux_result_data_d;
      aux_read_seen_q       <= aux_read_seen_d;
      rdata_q               <= rdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tick_q  <= tick_d;
    end
  end

endmodule : aim_top

// file: tb/aim_cpu_model.sv
// Purpose: Processor side of the register port
// Assumes: One-cycle strobes, read data in the following cycle
// Notes:   Released lines show inverted values, never the last ones
module aim_cpu_model (
  input  wire logic        clk,
  input  wire logic [31:0] bus_rdata,
  output      logic [31:0] bus_addr,
  output      logic [31:0] bus_wdata,
  output      logic        bus_wr,
  output      logic        bus_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    bus_addr  = 32'h0;
    bus_wdata = 32'h0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    @(posedge clk);
    d = bus_rdata;
  endtask : rd
endmodule : aim_cpu_model

// file: tb/aim_monitor.sv
// Purpose: Port-level checks for the ADC mask and mode block
// Assumes: One clock, synchronous active-low reset
// Notes:   Shadow mask follows bus writes to predict the request
module aim_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        primary_result_valid,
  input wire logic        aux_result_valid,
  input wire logic        accum_threshold_in,
  input wire logic        primary_threshold_in,
  input wire logic        primary_overrange_in,
  input wire logic        adc_irq,
  input wire logic        modulator_clock_select,
  input wire logic        modulator_clock_tick,
  input wire logic [1:0]  power_mode_field,
  input wire logic        low_power_enable,
  input wire logic        low_power_active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mask_q;
  logic [8:0] gap_q;
  logic       sel_q;
  wire        mask_wr = bus_wr && bus_addr == aim_pkg::OFF_IRQ_MASK;
  wire        mode_wr = bus_wr && bus_addr == aim_pkg::OFF_MODE;
  wire [6:0]  ev = {accum_threshold_in, 1'b0, primary_threshold_in,
                    primary_overrange_in, 1'b0, aux_result_valid,
                    primary_result_valid};
  wire        ev_on = |(ev & mask_q[6:0]);

  // Gap restarts on a rate change, so bounds hold across switches
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_q <= 8'h00;
      gap_q  <= 9'h000;
      sel_q  <= 1'b0;
    end else begin
      if (mask_wr) begin
        mask_q <= bus_wdata[7:0] & aim_pkg::FLAG_IMPL;
      end
      gap_q <= (modulator_clock_tick || modulator_clock_select != sel_q) ?
               9'h000 : gap_q + 9'h001;
      sel_q <= modulator_clock_select;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_RDATA_IDLE: assert property (
    !$past(bus_rd) |-> bus_rdata == 32'h0) else $error("stray read data");
  AST_RESET_OUT: assert property (
    $rose(resetn) |-> !adc_irq && !modulator_clock_select &&
    power_mode_field == 2'b00 && !low_power_enable)
    else $error("outputs wrong after reset");
  AST_MASK_OFF_QUIET: assert property (
    mask_q == 8'h00 |-> !adc_irq) else $error("request with mask clear");
  AST_EVENT_IRQ: assert property (
    ev_on && !bus_wr |=> adc_irq) else $error("enabled event lost");
  AST_SEL_WRITE: assert property (
    mode_wr |=> modulator_clock_select == $past(bus_wdata[7]))
    else $error("clock select not updated");
  AST_PM_WRITE: assert property (
    mode_wr |=> power_mode_field == $past(bus_wdata[4:3]))
    else $error("power mode field not updated");
  AST_LP_ACTIVE: assert property (
    low_power_active == power_mode_field[0]) else $error("low power code");
  AST_LP_IGNORED: assert property (
    !power_mode_field[0] |-> !low_power_enable) else $error("enable leak");
  AST_TICK_FAST: assert property (
    modulator_clock_select |-> gap_q < 9'd80) else $error("fast tick late");
  AST_TICK_SLOW: assert property (
    !modulator_clock_select |-> gap_q < 9'd310) else $error("slow tick late");
endmodule : aim_monitor

bind aim_top aim_monitor aim_monitor_i (
  .clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .primary_result_valid(primary_result_valid),
  .aux_result_valid(aux_result_valid),
  .accum_threshold_in(accum_threshold_in),
  .primary_threshold_in(primary_threshold_in),
  .primary_overrange_in(primary_overrange_in), .adc_irq(adc_irq),
  .modulator_clock_select(modulator_clock_select),
  .modulator_clock_tick(modulator_clock_tick),
  .power_mode_field(power_mode_field), .low_power_enable(low_power_enable),
  .low_power_active(low_power_active));

// file: tb/tb_aim_top.sv
// Purpose: Register, interrupt and mode tests for the ADC block
// Assumes: 40 MHz clock, reset held 8 cycles
// Notes:   Flag inputs share one vector indexed by status bit
module tb_aim_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, rv, v;
  logic        bus_wr, bus_rd, adc_irq, sel, tick, lpe, lpa;
  logic [1:0]  pmf;
  logic [7:0]  ev_q = 8'h00;
  logic [23:0] prim_in = 24'h0, aux_in = 24'h0;
  int          bad_count, n_compared, cyc, n;
  int          srcs[5] = '{0, 1, 3, 4, 6};

  always #12.5 clk = ~clk;

  aim_top aim_top_i (
    .clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .primary_result_valid(ev_q[0]), .primary_result_in(prim_in),
    .aux_result_valid(ev_q[1]), .aux_result_in(aux_in),
    .accum_threshold_in(ev_q[6]), .primary_threshold_in(ev_q[4]),
    .primary_overrange_in(ev_q[3]), .adc_irq(adc_irq),
    .modulator_clock_select(sel), .modulator_clock_tick(tick),
    .power_mode_field(pmf), .low_power_enable(lpe),
    .low_power_active(lpa));
  aim_cpu_model aim_cpu_model_i (
    .clk(clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic pulse(input int b);
    @(posedge clk);
    ev_q[b] <= 1'b1;
    @(posedge clk);
    ev_q[b] <= 1'b0;
    #1;
  endtask : pulse

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    aim_cpu_model_i.rd(aim_pkg::OFF_IRQ_MASK, rv);
    chk("mask reset", 32'h0, rv);
    aim_cpu_model_i.rd(aim_pkg::OFF_MODE, rv);
    chk("mode reset", 32'h3, rv);
    foreach (srcs[i]) begin
      pulse(srcs[i]);
      chk("irq blocked", 32'h0, 32'(adc_irq));
      aim_cpu_model_i.wr(aim_pkg::OFF_IRQ_MASK, 32'h1 << srcs[i]);
      #1;
      chk("irq enabled", 32'h1, 32'(adc_irq));
      aim_cpu_model_i.rd(aim_pkg::OFF_STATUS, rv);
      chk("flag", 32'h1 << srcs[i], rv & 32'h5b);
      aim_cpu_model_i.wr(aim_pkg::OFF_STATUS, 32'h1 << srcs[i]);
      #1;
      chk("irq cleared", 32'h0, 32'(adc_irq));
      aim_cpu_model_i.wr(aim_pkg::OFF_IRQ_MASK, 32'h0);
    end
    aim_cpu_model_i.wr(aim_pkg::OFF_IRQ_MASK, 32'hff);
    aim_cpu_model_i.rd(aim_pkg::OFF_IRQ_MASK, rv);
    chk("mask bits", 32'h5b, rv & 32'h5b);
    aim_cpu_model_i.wr(32'hffff0520, 32'h0);
    aim_cpu_model_i.rd(aim_pkg::OFF_IRQ_MASK, rv);
    chk("unmapped write", 32'hff, rv | 32'ha4);
    for (int c = 0; c < 4; c++) begin
      v = 32'h20 | 32'(c << 3) | (c[0] ? 32'h0 : 32'h80);
      aim_cpu_model_i.wr(aim_pkg::OFF_MODE, v);
      aim_cpu_model_i.rd(aim_pkg::OFF_MODE, rv);
      chk("mode", v, rv);
      chk("clk select", 32'(v[7]), 32'(sel));
      chk("power field", 32'(c), 32'(pmf));
      chk("low active", 32'(c[0]), 32'(lpa));
      chk("low enable", 32'(c[0]), 32'(lpe));
    end
    prim_in <= 24'h5a3c1e;
    aux_in  <= 24'hc3a5f0;
    pulse(0);
    pulse(1);
    aim_cpu_model_i.rd(aim_pkg::OFF_AUX_DATA, rv);
    chk("aux data", 32'hc3a5f0, rv);
    aim_cpu_model_i.rd(aim_pkg::OFF_STATUS, rv);
    chk("both ready", 32'h3, rv & 32'h3);
    aim_cpu_model_i.rd(aim_pkg::OFF_PRIMARY_DATA, rv);
    chk("primary data", 32'h5a3c1e, rv);
    aim_cpu_model_i.rd(aim_pkg::OFF_STATUS, rv);
    chk("ready cleared", 32'h0, rv & 32'h3);
    aim_cpu_model_i.wr(aim_pkg::OFF_MODE, 32'h80);
    n = 0;
    repeat (1000) @(posedge clk) n += int'(tick === 1'b1);
    chk("fast ticks", 32'h1, 32'(n inside {12, 13}));
    aim_cpu_model_i.wr(aim_pkg::OFF_MODE, 32'h00);
    n = 0;
    repeat (2000) @(posedge clk) n += int'(tick === 1'b1);
    chk("slow ticks", 32'h1, 32'(n inside {6, 7}));
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    aim_cpu_model_i.rd(aim_pkg::OFF_MODE, rv);
    chk("mode rereset", 32'h3, rv);
    aim_cpu_model_i.rd(aim_pkg::OFF_IRQ_MASK, rv);
    chk("mask rereset", 32'h0, rv);
    wrap_up();
  end
endmodule : tb_aim_top
